// *** core/rtbk_consts.svh ***
// Offsets, field positions and reset values of the channel register bank
// How it works
// - Four identical channel register sets exist, reached through the select register.
// - The select register keeps its target until software writes address 0xff again.
// - Address 0xff is always the select register and never a channel register.
// - Bit 3 of channel register 0 holds the core state machine in reset.
// - Bit 2 of channel register 0 returns the other channel registers to their defaults.
// - Bit 1 of channel register 0 holds the reference clock domain in reset.
// - Bit 0 of channel register 0 holds the divided oscillator domain in reset.
// - Bit 4 of register 1 is set when lock is lost after lock, and cleared on read.
// - Bit 0 of register 1 is set only when a detected signal later disappears.
// - Register 2 reports eight recovery status bits in a fixed order.
// - Register 3 holds four 2-bit boost fields, applied only with the override enable.
// - Register 8 holds the starting oscillator capacitor code, default zero.
// - Broadcast writes reach all four sets while reads use the chosen channel.
`ifndef RTBK_CONSTS_SVH
`define RTBK_CONSTS_SVH

// ****************************************
// Register addresses
// ****************************************
`define RTBK_ADDR_CHSEL      8'hFF
`define RTBK_ADDR_RST_CTRL   8'h00
`define RTBK_ADDR_EVT_FLAGS  8'h01
`define RTBK_ADDR_STATUS     8'h02
`define RTBK_ADDR_BOOST      8'h03
`define RTBK_ADDR_RSV_FIRST  8'h04
`define RTBK_ADDR_RSV_LAST   8'h07
`define RTBK_ADDR_START_CAP  8'h08

// ****************************************
// Field positions
// ****************************************
`define RTBK_SEL_BCAST_BIT   3
`define RTBK_SEL_EN_BIT      2
`define RTBK_RC_CORE_BIT     3
`define RTBK_RC_REGS_BIT     2
`define RTBK_RC_REF_BIT      1
`define RTBK_RC_VCO_BIT      0
`define RTBK_EF_LOCK_BIT     4
`define RTBK_EF_SIG_BIT      0
`define RTBK_ST_PPM_BIT      7
`define RTBK_ST_ADAPT_BIT    6
`define RTBK_ST_FAIL_BIT     5
`define RTBK_ST_LOCK_BIT     4
`define RTBK_ST_CDR_BIT      3
`define RTBK_ST_SBT_BIT      2
`define RTBK_ST_LPFH_BIT     1
`define RTBK_ST_LPFL_BIT     0

// ****************************************
// Reset values
// ****************************************
`define RTBK_SEL_RESET       4'h0
`define RTBK_RC_RESET        4'h0
`define RTBK_BOOST_RESET     8'h00
`define RTBK_RSV_RESET       8'h00
`define RTBK_CAP_RESET       5'h00
`define RTBK_RD_INVALID      8'h00

`endif

// *** core/rtbk_pkg.sv ***
// Types shared by the channel register bank
`default_nettype none
package rtbk_pkg;
    typedef logic [7:0] rtbk_byte_t;
    typedef logic [1:0] rtbk_chan_t;
    typedef logic [3:0] rtbk_rstctl_t;
    typedef logic [4:0] rtbk_cap_t;
endpackage
`default_nettype wire

// *** core/rtbk_evt.sv ***
// Sticky loss event flag armed by a prior high level
`timescale 1ns/10ps
`default_nettype none
module rtbk_evt
    import rtbk_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Monitored level and controls
    input  wire logic level,
    input  wire logic hold,
    input  wire logic clr,
    // Sticky flag
    output logic      flag_q
);
    logic armed_q;
    logic set_evt;

    assign set_evt = armed_q & ~level;

    // Arms once the level has been seen high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            armed_q <= 1'b0;
        end else if (hold) begin
            armed_q <= 1'b0;
        end else if (level) begin
            armed_q <= 1'b1;
        end else if (set_evt) begin
            armed_q <= 1'b0;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else if (set_evt) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end

    AST_EVT_SET: assert property (@(posedge clk) disable iff (!nrst)
        armed_q && !level |=> flag_q)
        else $error("loss after acquire did not set flag");
    AST_EVT_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        flag_q && clr && !set_evt |=> !flag_q)
        else $error("flag not cleared");
    AST_EVT_NO_ARM: assert property (@(posedge clk) disable iff (!nrst)
        !armed_q && !flag_q |=> !flag_q)
        else $error("flag set without prior acquire");
endmodule
`default_nettype wire

// *** core/rtbk_chan.sv ***
// Stored registers of one channel set
`timescale 1ns/10ps
`default_nettype none
`include "rtbk_consts.svh"
module rtbk_chan
    import rtbk_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Write port
    input  wire logic       wr,
    input  wire rtbk_byte_t addr,
    input  wire rtbk_byte_t wdata,
    // Boost override enable
    input  wire logic       boost_ovr_en,
    // Read data of stored registers
    output var  rtbk_byte_t rdata,
    // Reset controls
    output logic            core_rst,
    output logic            regs_rst,
    output logic            ref_rst,
    output logic            vco_rst,
    // Boost and capacitor settings
    output logic [1:0]      boost_stage0_field,
    output logic [1:0]      boost_stage1_field,
    output logic [1:0]      boost_stage2_field,
    output logic [1:0]      boost_stage3_field,
    output logic            boost_force_q,
    output var  rtbk_cap_t  start_cap_code
);
    rtbk_rstctl_t rst_ctl_q;
    rtbk_byte_t   boost_q;
    rtbk_cap_t    cap_q;
    rtbk_byte_t   rsv_q [4];

    assign core_rst           = rst_ctl_q[`RTBK_RC_CORE_BIT];
    assign regs_rst           = rst_ctl_q[`RTBK_RC_REGS_BIT];
    assign ref_rst            = rst_ctl_q[`RTBK_RC_REF_BIT];
    assign vco_rst            = rst_ctl_q[`RTBK_RC_VCO_BIT];
    assign boost_stage0_field = boost_q[7:6];
    assign boost_stage1_field = boost_q[5:4];
    assign boost_stage2_field = boost_q[3:2];
    assign boost_stage3_field = boost_q[1:0];
    assign start_cap_code     = cap_q;

    // Reset bits stay set until rewritten
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_ctl_q <= `RTBK_RC_RESET;
        end else if (wr && addr == `RTBK_ADDR_RST_CTRL) begin
            rst_ctl_q <= wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boost_q <= `RTBK_BOOST_RESET;
        end else if (regs_rst) begin
            boost_q <= `RTBK_BOOST_RESET;
        end else if (wr && addr == `RTBK_ADDR_BOOST) begin
            boost_q <= wdata;
        end
    end

    // Fields force the boost only under the override enable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boost_force_q <= 1'b0;
        end else begin
            boost_force_q <= boost_ovr_en;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cap_q <= `RTBK_CAP_RESET;
        end else if (regs_rst) begin
            cap_q <= `RTBK_CAP_RESET;
        end else if (wr && addr == `RTBK_ADDR_START_CAP) begin
            cap_q <= wdata[4:0];
        end
    end

    for (genvar k = 0; k < 4; k++) begin : g_rsv
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                rsv_q[k] <= `RTBK_RSV_RESET;
            end else if (regs_rst) begin
                rsv_q[k] <= `RTBK_RSV_RESET;
            end else if (wr && addr == (`RTBK_ADDR_RSV_FIRST + 8'(k))) begin
                rsv_q[k] <= wdata;
            end
        end
    end

    always_comb begin
        rdata = `RTBK_RD_INVALID;
        if (addr == `RTBK_ADDR_RST_CTRL) begin
            rdata = {4'h0, rst_ctl_q};
        end else if (addr == `RTBK_ADDR_BOOST) begin
            rdata = boost_q;
        end else if (addr == `RTBK_ADDR_START_CAP) begin
            rdata = {3'h0, cap_q};
        end else if (addr >= `RTBK_ADDR_RSV_FIRST &&
                     addr <= `RTBK_ADDR_RSV_LAST) begin
            rdata = rsv_q[addr[1:0]];
        end
    end

    AST_CORE_BIT: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == `RTBK_ADDR_RST_CTRL |=> core_rst == $past(wdata[3]))
        else $error("core reset bit not taken");
    AST_REF_BIT: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == `RTBK_ADDR_RST_CTRL |=> ref_rst == $past(wdata[1]))
        else $error("ref reset bit not taken");
    AST_VCO_BIT: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == `RTBK_ADDR_RST_CTRL |=> vco_rst == $past(wdata[0]))
        else $error("vco reset bit not taken");
    AST_RST_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        core_rst && ref_rst && !(wr && addr == `RTBK_ADDR_RST_CTRL)
        |=> core_rst && ref_rst)
        else $error("reset bit dropped without a write");
    AST_REGS_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
        regs_rst |=> boost_q == `RTBK_BOOST_RESET && cap_q == `RTBK_CAP_RESET)
        else $error("registers not at defaults under register reset");
    AST_CAP_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == `RTBK_ADDR_START_CAP && !regs_rst
        |=> cap_q == rtbk_cap_t'($past(wdata)))
        else $error("start cap code not written");
endmodule
`default_nettype wire

// *** core/rtbk_top.sv ***
// Channel register bank with select register and four channel sets
`timescale 1ns/10ps
`default_nettype none
`include "rtbk_consts.svh"
module rtbk_top
    import rtbk_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Register access port
    input  wire rtbk_byte_t       reg_addr,
    input  wire rtbk_byte_t       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output var  rtbk_byte_t       reg_rdata_q,
    output logic                  reg_rvalid_q,
    // Recovery status per channel
    input  wire logic [3:0]       freq_count_met,
    input  wire logic [3:0]       adapt_done,
    input  wire logic [3:0]       lock_check_fail,
    input  wire logic [3:0]       lock_state,
    input  wire logic [3:0]       cdr_lock,
    input  wire logic [3:0]       sbt_limit,
    input  wire logic [3:0]       lpf_high,
    input  wire logic [3:0]       lpf_low,
    // Signal detect and boost override per channel
    input  wire logic [3:0]       sig_det,
    input  wire logic [3:0]       boost_ovr_en,
    // Reset controls per channel
    output logic [3:0]            core_rst,
    output logic [3:0]            regs_rst,
    output logic [3:0]            ref_rst,
    output logic [3:0]            vco_rst,
    // Boost and capacitor settings per channel
    output logic [3:0][1:0]       boost_stage0_field,
    output logic [3:0][1:0]       boost_stage1_field,
    output logic [3:0][1:0]       boost_stage2_field,
    output logic [3:0][1:0]       boost_stage3_field,
    output logic [3:0]            boost_force,
    output logic [3:0][4:0]       start_cap_code,
    // Event flags per channel
    output logic [3:0]            lock_lost_flag,
    output logic [3:0]            signal_lost_flag
);
    // ****************************************
    // Channel select register
    // ****************************************
    logic [3:0]   sel_q;
    logic         sel_wr;
    logic         sel_en;
    logic         sel_bcast;
    rtbk_chan_t   sel_ch;
    logic         chan_acc;
    logic [3:0]   wr_ch;
    logic [3:0]   rd_clr;
    rtbk_byte_t   chan_rdata [4];
    rtbk_byte_t   status_byte [4];
    rtbk_byte_t   rd_byte;
    rtbk_byte_t   boost_byte [4];

    // Address 0xff never reaches a channel set
    assign sel_wr    = reg_wr && reg_addr == `RTBK_ADDR_CHSEL;
    assign sel_en    = sel_q[`RTBK_SEL_EN_BIT];
    assign sel_bcast = sel_q[`RTBK_SEL_BCAST_BIT];
    assign sel_ch    = sel_q[1:0];
    assign chan_acc  = sel_en && reg_addr != `RTBK_ADDR_CHSEL;

    // Upper four bits of the select value are dropped
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_q <= `RTBK_SEL_RESET;
        end else if (sel_wr) begin
            sel_q <= reg_wdata[3:0];
        end
    end

    // ****************************************
    // Channel sets
    // ****************************************
    for (genvar i = 0; i < 4; i++) begin : g_ch
        // Broadcast reaches every set, else only the chosen one
        assign wr_ch[i] = reg_wr && chan_acc &&
                          (sel_bcast || sel_ch == rtbk_chan_t'(i));
        assign rd_clr[i] = reg_rd && chan_acc &&
                           reg_addr == `RTBK_ADDR_EVT_FLAGS &&
                           sel_ch == rtbk_chan_t'(i);

        always_comb begin
            status_byte[i] = `RTBK_RD_INVALID;
            status_byte[i][`RTBK_ST_PPM_BIT]   = freq_count_met[i];
            status_byte[i][`RTBK_ST_ADAPT_BIT] = adapt_done[i];
            status_byte[i][`RTBK_ST_FAIL_BIT]  = lock_check_fail[i];
            status_byte[i][`RTBK_ST_LOCK_BIT]  = lock_state[i];
            status_byte[i][`RTBK_ST_CDR_BIT]   = cdr_lock[i];
            status_byte[i][`RTBK_ST_SBT_BIT]   = sbt_limit[i];
            status_byte[i][`RTBK_ST_LPFH_BIT]  = lpf_high[i];
            status_byte[i][`RTBK_ST_LPFL_BIT]  = lpf_low[i];
        end

        assign boost_byte[i] = {boost_stage0_field[i], boost_stage1_field[i],
                                boost_stage2_field[i], boost_stage3_field[i]};

        rtbk_chan u_chan (
            .clk                (clk),
            .nrst               (nrst),
            .wr                 (wr_ch[i]),
            .addr               (reg_addr),
            .wdata              (reg_wdata),
            .boost_ovr_en       (boost_ovr_en[i]),
            .rdata              (chan_rdata[i]),
            .core_rst           (core_rst[i]),
            .regs_rst           (regs_rst[i]),
            .ref_rst            (ref_rst[i]),
            .vco_rst            (vco_rst[i]),
            .boost_stage0_field (boost_stage0_field[i]),
            .boost_stage1_field (boost_stage1_field[i]),
            .boost_stage2_field (boost_stage2_field[i]),
            .boost_stage3_field (boost_stage3_field[i]),
            .boost_force_q      (boost_force[i]),
            .start_cap_code     (start_cap_code[i])
        );

        // Lock loss only counts while the core runs
        rtbk_evt u_lock_evt (
            .clk    (clk),
            .nrst   (nrst),
            .level  (cdr_lock[i]),
            .hold   (core_rst[i]),
            .clr    (rd_clr[i] | regs_rst[i]),
            .flag_q (lock_lost_flag[i])
        );

        // Signal loss is not cleared by reading
        rtbk_evt u_sig_evt (
            .clk    (clk),
            .nrst   (nrst),
            .level  (sig_det[i]),
            .hold   (1'b0),
            .clr    (regs_rst[i]),
            .flag_q (signal_lost_flag[i])
        );
    end

    // ****************************************
    // Read path
    // ****************************************
    // Reads follow the chosen channel even under broadcast
    always_comb begin
        rd_byte = `RTBK_RD_INVALID;
        if (chan_acc) begin
            case (reg_addr)
                `RTBK_ADDR_EVT_FLAGS: begin
                    rd_byte = `RTBK_RD_INVALID;
                    rd_byte[`RTBK_EF_LOCK_BIT] = lock_lost_flag[sel_ch];
                    rd_byte[`RTBK_EF_SIG_BIT]  = signal_lost_flag[sel_ch];
                end
                `RTBK_ADDR_STATUS: begin
                    rd_byte = status_byte[sel_ch];
                end
                default: begin
                    rd_byte = chan_rdata[sel_ch];
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= `RTBK_RD_INVALID;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_byte;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence seq_chan_rd(logic [7:0] a);
        reg_rd && !reg_wr && chan_acc && reg_addr == a;
    endsequence

    sequence seq_bcast_boost_wr;
        reg_wr && sel_en && sel_bcast && reg_addr == `RTBK_ADDR_BOOST &&
        regs_rst == 4'h0;
    endsequence

    AST_SEL_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !sel_wr |=> $stable(sel_q))
        else $error("select changed without a write to 0xff");

    AST_RVALID: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd |=> reg_rvalid_q ##1 (!reg_rvalid_q || $past(reg_rd)))
        else $error("read answer timing wrong");

    AST_READ_STATUS: assert property (@(posedge clk) disable iff (!nrst)
        seq_chan_rd(`RTBK_ADDR_STATUS)
        |=> reg_rdata_q == $past(status_byte[sel_ch]))
        else $error("status read mismatch");

    AST_READ_BOOST: assert property (@(posedge clk) disable iff (!nrst)
        seq_chan_rd(`RTBK_ADDR_BOOST)
        |=> reg_rdata_q == $past(boost_byte[sel_ch]))
        else $error("boost read not from chosen channel");

    AST_READ_FLAGS: assert property (@(posedge clk) disable iff (!nrst)
        seq_chan_rd(`RTBK_ADDR_EVT_FLAGS)
        |=> reg_rdata_q == {3'h0, $past(lock_lost_flag[sel_ch]), 3'h0,
                            $past(signal_lost_flag[sel_ch])})
        else $error("event flag read mismatch");

    AST_FF_READ_ZERO: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `RTBK_ADDR_CHSEL
        |=> reg_rdata_q == `RTBK_RD_INVALID)
        else $error("read of 0xff returned data");

    AST_SHARED_READ: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && !sel_en |=> reg_rdata_q == `RTBK_RD_INVALID)
        else $error("channel data seen with channel access off");

    for (genvar j = 0; j < 4; j++) begin : g_chk
        AST_BCAST_ALL: assert property (@(posedge clk) disable iff (!nrst)
            seq_bcast_boost_wr |=> boost_byte[j] == $past(reg_wdata))
            else $error("broadcast write missed a channel");

        AST_TARGET_ONLY: assert property (@(posedge clk) disable iff (!nrst)
            reg_wr && sel_en && !sel_bcast && sel_ch != rtbk_chan_t'(j) &&
            reg_addr == `RTBK_ADDR_BOOST && !regs_rst[j]
            |=> $stable(boost_byte[j]))
            else $error("write reached a channel not selected");

        AST_FF_ISOLATED: assert property (@(posedge clk) disable iff (!nrst)
            sel_wr && !regs_rst[j]
            |=> $stable(boost_byte[j]) && $stable(start_cap_code[j]) &&
                $stable(core_rst[j]) && $stable(vco_rst[j]))
            else $error("write to 0xff touched a channel");

        AST_LOCK_READ_CLR: assert property (@(posedge clk) disable iff (!nrst)
            rd_clr[j] && lock_lost_flag[j] && !$fell(cdr_lock[j])
            |=> !lock_lost_flag[j])
            else $error("lock loss flag not cleared by read");
    end
endmodule
`default_nettype wire

// *** dv/rtbk_host.sv ***
// Management host model driving the register access port
`timescale 1ns/10ps
`default_nettype none
module rtbk_host
    import rtbk_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Register access port
    output var  rtbk_byte_t reg_addr,
    output var  rtbk_byte_t reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One access, held until the edge that takes it
    task automatic access(input logic wr, input rtbk_byte_t a,
                          input rtbk_byte_t d);
        @(posedge clk);
        #2;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = wr;
        reg_rd    = ~wr;
        @(posedge clk);
        #2;
        // Strobes drop low; address and data show the inverse of the last value
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// *** dv/tb_rtbk_top.sv ***
// Self-checking bench of the channel register bank
`timescale 1ns/10ps
`default_nettype none
module tb_rtbk_top
    import rtbk_pkg::*;
;
    logic            clk, nrst, reg_wr, reg_rd, reg_rvalid_q;
    rtbk_byte_t      reg_addr, reg_wdata, reg_rdata_q;
    logic [3:0]      freq_count_met, adapt_done, lock_check_fail, lock_state;
    logic [3:0]      cdr_lock, sbt_limit, lpf_high, lpf_low;
    logic [3:0]      sig_det, boost_ovr_en, boost_force;
    logic [3:0]      core_rst, regs_rst, ref_rst, vco_rst;
    logic [3:0]      lock_lost_flag, signal_lost_flag;
    logic [3:0][1:0] boost_stage0_field, boost_stage1_field;
    logic [3:0][1:0] boost_stage2_field, boost_stage3_field;
    logic [3:0][4:0] start_cap_code;
    int              error_cnt, check_count, seed;
    rtbk_byte_t      exp_q[$];
    rtbk_byte_t      v[4];

    rtbk_top i_dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata_q, .reg_rvalid_q, .freq_count_met, .adapt_done,
        .lock_check_fail, .lock_state, .cdr_lock, .sbt_limit, .lpf_high,
        .lpf_low, .sig_det, .boost_ovr_en, .core_rst, .regs_rst, .ref_rst,
        .vco_rst, .boost_stage0_field, .boost_stage1_field,
        .boost_stage2_field, .boost_stage3_field, .boost_force,
        .start_cap_code, .lock_lost_flag, .signal_lost_flag);
    rtbk_host i_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_rd(input rtbk_byte_t g);
        rtbk_byte_t e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH reg_rdata_q expected %h seen %h", e, g);
        end
    endtask

    // Read answers are matched against the oldest note
    always @(negedge clk) begin
        if (reg_rvalid_q === 1'b1) begin
            chk_rd(reg_rdata_q);
        end
    end

    task automatic wr(input rtbk_byte_t a, input rtbk_byte_t d);
        i_host.access(1'b1, a, d);
    endtask
    task automatic rd(input rtbk_byte_t a, input rtbk_byte_t e);
        exp_q.push_back(e);
        i_host.access(1'b0, a, 8'h00);
    endtask
    task automatic sel(input logic [3:0] s);
        wr(8'hFF, {4'h0, s});
    endtask
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask
    task automatic tick;
        @(posedge clk);
        #2;
    endtask
    function automatic rtbk_byte_t bst(input int c);
        return {boost_stage0_field[c], boost_stage1_field[c],
                boost_stage2_field[c], boost_stage3_field[c]};
    endfunction
    function automatic logic [15:0] rsts();
        return {core_rst, regs_rst, ref_rst, vco_rst};
    endfunction

    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        end_of_test;
    end

    initial begin
        seed = 37179;
        nrst = 1'b0;
        {freq_count_met, adapt_done, lock_check_fail, lock_state} = 16'h0000;
        {cdr_lock, sbt_limit, lpf_high, lpf_low} = 16'h0000;
        {sig_det, boost_ovr_en} = 8'h00;
        repeat (10) @(posedge clk);
        #2 nrst = 1'b1;
        settle;
        chk("reset controls", 16'h0000, rsts());
        rd(8'h03, 8'h00);
        wr(8'h03, 8'hFF);
        settle;
        chk("boost fields", 16'h0000, 16'(bst(0)));
        $display("test unselected done");
        for (int c = 0; c < 4; c++) begin
            v[c] = 8'($random(seed));
            sel(4'h4 | 4'(c));
            wr(8'h03, v[c]);
            wr(8'h08, {3'h0, v[c][4:0]});
        end
        settle;
        for (int c = 0; c < 4; c++) begin
            chk("boost fields", 16'(v[c]), 16'(bst(c)));
            chk("start_cap_code", 16'(v[c][4:0]), 16'(start_cap_code[c]));
        end
        rd(8'h03, v[3]);
        rd(8'hFF, 8'h00);
        sel(4'h7);
        rd(8'h08, {3'h0, v[3][4:0]});
        wr(8'h05, 8'hA5);
        rd(8'h05, 8'hA5);
        rd(8'h09, 8'h00);
        $display("test channel sets done");
        sel(4'hD);
        wr(8'h03, 8'hE4);
        settle;
        for (int c = 0; c < 4; c++) begin
            chk("boost fields", 16'h00E4, 16'(bst(c)));
        end
        rd(8'h08, {3'h0, v[1][4:0]});
        $display("test broadcast done");
        sel(4'h6);
        for (int b = 0; b < 4; b++) begin
            wr(8'h00, 8'(1 << b));
            settle;
            chk("reset controls", 16'h0004 << (4 * b), rsts());
        end
        wr(8'h00, 8'h0F);
        settle;
        chk("cleared regs", 16'h0000, {bst(2), 3'h0, start_cap_code[2]});
        wr(8'h03, 8'h55);
        rd(8'h03, 8'h00);
        rd(8'h00, 8'h0F);
        repeat (20) @(negedge clk);
        chk("reset controls", 16'h4444, rsts());
        wr(8'h00, 8'h00);
        settle;
        chk("reset controls", 16'h0000, rsts());
        $display("test reset controls done");
        sel(4'h5);
        tick;
        sig_det = 4'h2;
        repeat (3) tick;
        sig_det = 4'h0;
        settle;
        chk("signal_lost_flag", 16'h0002, 16'(signal_lost_flag));
        rd(8'h01, 8'h01);
        tick;
        cdr_lock = 4'h2;
        repeat (3) tick;
        cdr_lock = 4'h0;
        settle;
        chk("lock_lost_flag", 16'h0002, 16'(lock_lost_flag));
        rd(8'h01, 8'h11);
        settle;
        chk("lock_lost_flag", 16'h0000, 16'(lock_lost_flag));
        rd(8'h01, 8'h01);
        wr(8'h00, 8'h08);
        cdr_lock = 4'h2;
        repeat (3) tick;
        cdr_lock = 4'h0;
        settle;
        chk("lock_lost_flag", 16'h0000, 16'(lock_lost_flag));
        wr(8'h00, 8'h00);
        tick;
        boost_ovr_en = 4'($random(seed));
        settle;
        chk("boost_force", 16'(boost_ovr_en), 16'(boost_force));
        $display("test events done");
        for (int c = 0; c < 4; c++) begin
            sel(4'h4 | 4'(c));
            tick;
            {freq_count_met, adapt_done, lock_check_fail, lock_state,
             cdr_lock, sbt_limit, lpf_high, lpf_low} = $random(seed);
            rd(8'h02, {freq_count_met[c], adapt_done[c], lock_check_fail[c],
                       lock_state[c], cdr_lock[c], sbt_limit[c],
                       lpf_high[c], lpf_low[c]});
        end
        settle;
        chk("pending reads", 16'h0000, 16'(exp_q.size()));
        $display("test status done");
        end_of_test;
    end
endmodule
`default_nettype wire
